/* drpc_consts.svh */
// Constants for the reset, calibration and power-down control block.
// Summary of operation
// - Mode-register reset in idle restores defaults and enters auto-initialization.
// - Array is marked invalid by a mode-register reset and valid again once it completes.
// - Four calibrations started by writes to register 0Ah, each with own duration.
// - Reference tied to supply: ignore calibration commands, keep default impedance.
// - After calibration completes, the reference pin circuitry is switched off.
// - Enable low with select high enters power-down; no-operation follows.
// - Power-down is idle with all banks idle, active with any row open.
// - Power-down disables buffers except clock and enable; enable low for minimum time.
// - No refresh in power-down; controller limits its duration.
// - Enable low, select low, bits 0,1 high, bit 2 low enters deep sleep.
// - Deep sleep loses array contents and disables buffers and internal power.
// - Select and command bits 0 to 3 low recognise a mode-register write.
// - No-operation is select high, or select low with bits 0 to 2 high.
`ifndef DRPC_CONSTS_SVH
`define DRPC_CONSTS_SVH

// ==========================================================
// Mode register addresses and calibration codes
// ==========================================================
`define DRPC_MA_RESET        8'h3f
`define DRPC_MA_CAL          8'h0a
`define DRPC_OP_CAL_INIT     8'hff
`define DRPC_OP_CAL_LONG     8'hab
`define DRPC_OP_CAL_SHORT    8'h56
`define DRPC_OP_CAL_DEFAULT  8'hc3
`define DRPC_MR_DEFAULT      8'h00

// ==========================================================
// Timing figures in nanoseconds and derived cycle counts
// ==========================================================
`define DRPC_CLK_NS          8
`define DRPC_T_INIT_NS       1000000
`define DRPC_T_SETTLE_NS     1000
`define DRPC_T_CAL_INIT_NS   1000000
`define DRPC_T_CAL_LONG_NS   360
`define DRPC_T_CAL_SHORT_NS  90
`define DRPC_T_CAL_RST_NS    50
`define DRPC_T_MRW_CYC       5
`define DRPC_CYC_UP(ns)      (((ns) + `DRPC_CLK_NS - 1) / `DRPC_CLK_NS)

`endif

/* drpc_pkg.sv */
// Types shared by the reset, calibration and power-down control block.
`default_nettype none
package drpc_pkg;
	typedef enum logic [2:0]
	{
		DRPC_IDLE     = 3'b000,
		DRPC_ACTIVE   = 3'b001,
		DRPC_RESETTING = 3'b010,
		DRPC_PD_IDLE  = 3'b011,
		DRPC_PD_ACT   = 3'b100,
		DRPC_DEEP     = 3'b101
	} drpc_state_t;

	typedef enum logic [2:0]
	{
		DRPC_CMD_NOP    = 3'b000,
		DRPC_CMD_MRW    = 3'b001,
		DRPC_CMD_ACT    = 3'b010,
		DRPC_CMD_PRE    = 3'b011,
		DRPC_CMD_OTHER  = 3'b100
	} drpc_cmd_t;
endpackage : drpc_pkg
`default_nettype wire

/* drpc_cmd_decode.sv */
// Command decoder for the first edge of a command.
`default_nettype none
module drpc_cmd_decode
(
	// Command pins
	input  wire logic            cs_n_i,
	input  wire logic [3:0]      ca_i,
	// Decoded class
	output drpc_pkg::drpc_cmd_t  cmd_o
);
	always_comb
	begin
		if (cs_n_i || ca_i[2:0] == 3'b111)
			cmd_o = drpc_pkg::DRPC_CMD_NOP;
		else if (ca_i == 4'h0)
			cmd_o = drpc_pkg::DRPC_CMD_MRW;
		else if (ca_i[1:0] == 2'b10)
			cmd_o = drpc_pkg::DRPC_CMD_ACT;
		else if (ca_i[2:0] == 3'b011 && ca_i[3])
			cmd_o = drpc_pkg::DRPC_CMD_PRE;
		else
			cmd_o = drpc_pkg::DRPC_CMD_OTHER;
	end
endmodule : drpc_cmd_decode
`default_nettype wire

/* drpc_timer.sv */
// Down counter that marks a busy period of a loaded length.
`default_nettype none
module drpc_timer
#(
	parameter int W = 20
)
(
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         sys_rst_i,
	// Load and status
	input  wire logic         load_i,
	input  wire logic [W-1:0] count_i,
	output logic              busy_o,
	output logic              done_o
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         done_d;
	logic         done_q;

	always_comb
	begin
		cnt_d  = cnt_q;
		done_d = 1'b0;
		if (load_i)
			cnt_d = count_i;
		else if (cnt_q != '0)
		begin
			cnt_d  = cnt_q - 1'b1;
			done_d = (cnt_q == {{(W-1){1'b0}}, 1'b1});
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end

	assign busy_o = (cnt_q != '0);
	assign done_o = done_q;
endmodule : drpc_timer
`default_nettype wire

/* drpc_ctrl.sv */
// Device-side reset, impedance calibration and power-down control.
`include "drpc_consts.svh"
`default_nettype none
module drpc_ctrl
#(
	parameter int TW          = 20,
	parameter int INIT_CYC    = `DRPC_CYC_UP(`DRPC_T_INIT_NS),
	parameter int CAL_INIT_CYC = `DRPC_CYC_UP(`DRPC_T_CAL_INIT_NS)
)
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// Command pins, rising edge then falling edge halves
	input  wire logic       cke_i,
	input  wire logic       cs_n_i,
	input  wire logic [9:0] ca_rise_i,
	input  wire logic [9:0] ca_fall_i,
	// Reference pin strap, high when tied to the command supply
	input  wire logic       ref_tied_i,
	// Status
	output logic            busy_o,
	output logic            in_power_down_o,
	output logic            active_power_down_o,
	output logic            in_deep_sleep_o,
	output logic            buffers_on_o,
	output logic            core_power_on_o,
	output logic            array_valid_o,
	output logic            cal_ref_on_o,
	output logic            cal_default_o,
	output logic [7:0]      cal_reg_o,
	output logic            mr_reset_o
);
	// ==========================================================
	// Decode
	// ==========================================================
	drpc_pkg::drpc_cmd_t cmd;
	drpc_pkg::drpc_state_t st_q;
	drpc_pkg::drpc_state_t st_d;
	logic       cke_prev_q;
	logic [7:0] ma;
	logic [7:0] op;
	logic       mode_reg_write_cmd;
	logic       deep_entry;
	logic       pd_entry;

	drpc_cmd_decode u_dec
	(
		.cs_n_i (cs_n_i),
		.ca_i   (ca_rise_i[3:0]),
		.cmd_o  (cmd)
	);

	assign ma = {ca_fall_i[1:0], ca_rise_i[9:4]};
	assign op = ca_fall_i[9:2];
	assign mode_reg_write_cmd = cke_prev_q && cke_i && cmd == drpc_pkg::DRPC_CMD_MRW;
	assign pd_entry = cke_prev_q && !cke_i && cs_n_i;
	assign deep_entry = cke_prev_q && !cke_i && !cs_n_i
		&& ca_rise_i[2:0] == 3'b011;

	// ==========================================================
	// Timers for reset initialization and calibration
	// ==========================================================
	logic          init_load;
	logic          cal_load;
	logic [TW-1:0] cal_len;
	logic          init_busy;
	logic          init_done;
	logic          cal_busy;
	logic          cal_done;

	drpc_timer #(.W(TW)) u_init
	(
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (init_load),
		.count_i   (TW'(INIT_CYC)),
		.busy_o    (init_busy),
		.done_o    (init_done)
	);

	drpc_timer #(.W(TW)) u_cal
	(
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (cal_load),
		.count_i   (cal_len),
		.busy_o    (cal_busy),
		.done_o    (cal_done)
	);

	// ==========================================================
	// Calibration start
	// ==========================================================
	logic cal_cmd;
	logic cal_known;

	assign cal_cmd = mode_reg_write_cmd && ma == `DRPC_MA_CAL && st_q == drpc_pkg::DRPC_IDLE;

	always_comb
	begin
		cal_known = 1'b1;
		unique case (op)
			`DRPC_OP_CAL_INIT:    cal_len = TW'(CAL_INIT_CYC);
			`DRPC_OP_CAL_LONG:    cal_len = TW'(`DRPC_CYC_UP(`DRPC_T_CAL_LONG_NS));
			`DRPC_OP_CAL_SHORT:   cal_len = TW'(`DRPC_CYC_UP(`DRPC_T_CAL_SHORT_NS));
			`DRPC_OP_CAL_DEFAULT: cal_len = TW'(`DRPC_CYC_UP(`DRPC_T_CAL_RST_NS));
			default:
			begin
				cal_len   = '0;
				cal_known = 1'b0;
			end
		endcase
	end

	// A tied reference pin turns every calibration request into a no-op.
	assign cal_load = cal_cmd && cal_known && !ref_tied_i && !cal_busy;

	// ==========================================================
	// Main state and output registers
	// ==========================================================
	logic [7:0] cal_reg_q;
	logic [7:0] cal_reg_d;
	logic       cal_def_q;
	logic       cal_def_d;
	logic       cal_ref_q;
	logic       cal_ref_d;
	logic       arr_q;
	logic       arr_d;
	logic       mr_rst_q;
	logic       mr_rst_d;
	logic [3:0] mrw_cnt_q;
	logic [3:0] mrw_cnt_d;

	always_comb
	begin
		st_d      = st_q;
		cal_reg_d = cal_reg_q;
		cal_def_d = cal_def_q;
		cal_ref_d = cal_ref_q;
		arr_d     = arr_q;
		mr_rst_d  = 1'b0;
		mrw_cnt_d = (mrw_cnt_q != 4'h0) ? mrw_cnt_q - 4'h1 : 4'h0;
		init_load = 1'b0;
		// A calibration accepted as the previous one ends must keep the reference on.
		if (cal_done)
			cal_ref_d = 1'b0;
		if (cal_load)
		begin
			cal_reg_d = op;
			cal_ref_d = 1'b1;
			cal_def_d = (op == `DRPC_OP_CAL_DEFAULT);
		end
		if (ref_tied_i)
			cal_def_d = 1'b1;
		if (mode_reg_write_cmd)
			mrw_cnt_d = 4'(`DRPC_T_MRW_CYC);
		unique case (st_q)
			drpc_pkg::DRPC_IDLE,
			drpc_pkg::DRPC_ACTIVE:
			begin
				if (st_q == drpc_pkg::DRPC_IDLE && cmd == drpc_pkg::DRPC_CMD_ACT
					&& cke_i)
					st_d = drpc_pkg::DRPC_ACTIVE;
				if (st_q == drpc_pkg::DRPC_ACTIVE && cmd == drpc_pkg::DRPC_CMD_PRE
					&& cke_i && ca_rise_i[4])
					st_d = drpc_pkg::DRPC_IDLE;
				if (mode_reg_write_cmd && ma == `DRPC_MA_RESET && st_q == drpc_pkg::DRPC_IDLE)
				begin
					st_d      = drpc_pkg::DRPC_RESETTING;
					cal_reg_d = `DRPC_MR_DEFAULT;
					cal_def_d = 1'b1;
					arr_d     = 1'b0;
					mr_rst_d  = 1'b1;
					init_load = 1'b1;
				end
				else if (deep_entry)
				begin
					st_d  = drpc_pkg::DRPC_DEEP;
					arr_d = 1'b0;
				end
				else if (pd_entry)
					st_d = (st_q == drpc_pkg::DRPC_IDLE) ? drpc_pkg::DRPC_PD_IDLE
						: drpc_pkg::DRPC_PD_ACT;
			end
			drpc_pkg::DRPC_RESETTING:
			begin
				if (init_done)
					st_d = drpc_pkg::DRPC_IDLE;
			end
			drpc_pkg::DRPC_PD_IDLE:
			begin
				if (cke_i)
					st_d = drpc_pkg::DRPC_IDLE;
			end
			drpc_pkg::DRPC_PD_ACT:
			begin
				if (cke_i)
					st_d = drpc_pkg::DRPC_ACTIVE;
			end
			drpc_pkg::DRPC_DEEP:
			begin
				// Waking needs full re-initialisation, which the reset timer models.
				if (cke_i)
				begin
					st_d      = drpc_pkg::DRPC_RESETTING;
					cal_reg_d = `DRPC_MR_DEFAULT;
					cal_def_d = 1'b1;
					init_load = 1'b1;
				end
			end
			default:
				st_d = drpc_pkg::DRPC_IDLE;
		endcase
		if (init_done)
			arr_d = 1'b1;
	end

	logic in_pd;
	logic in_deep;

	assign in_pd   = st_d == drpc_pkg::DRPC_PD_IDLE || st_d == drpc_pkg::DRPC_PD_ACT;
	assign in_deep = st_d == drpc_pkg::DRPC_DEEP;

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			st_q                <= drpc_pkg::DRPC_IDLE;
			cke_prev_q          <= 1'b0;
			cal_reg_q           <= `DRPC_MR_DEFAULT;
			cal_def_q           <= 1'b1;
			cal_ref_q           <= 1'b0;
			arr_q               <= 1'b0;
			mr_rst_q            <= 1'b0;
			mrw_cnt_q           <= 4'h0;
			busy_o              <= 1'b0;
			in_power_down_o     <= 1'b0;
			active_power_down_o <= 1'b0;
			in_deep_sleep_o     <= 1'b0;
			buffers_on_o        <= 1'b1;
			core_power_on_o     <= 1'b1;
		end
		else
		begin
			st_q                <= st_d;
			cke_prev_q          <= cke_i;
			cal_reg_q           <= cal_reg_d;
			cal_def_q           <= cal_def_d;
			cal_ref_q           <= cal_ref_d;
			arr_q               <= arr_d;
			mr_rst_q            <= mr_rst_d;
			mrw_cnt_q           <= mrw_cnt_d;
			busy_o              <= init_busy || init_load || cal_busy || cal_load
				|| mrw_cnt_d != 4'h0;
			in_power_down_o     <= in_pd;
			active_power_down_o <= st_d == drpc_pkg::DRPC_PD_ACT;
			in_deep_sleep_o     <= in_deep;
			buffers_on_o        <= !in_pd && !in_deep;
			core_power_on_o     <= !in_deep;
		end
	end

	assign array_valid_o = arr_q;
	assign cal_ref_on_o  = cal_ref_q;
	assign cal_default_o = cal_def_q;
	assign cal_reg_o     = cal_reg_q;
	assign mr_reset_o    = mr_rst_q;
endmodule : drpc_ctrl
`default_nettype wire

/* drpc_ctrl_sva.sv */
// Port assertions for the reset, calibration and power-down block.
`default_nettype none
module drpc_ctrl_sva
(
	// Clock and reset
	input wire logic       clk_i,
	input wire logic       sys_rst_i,
	// Pins
	input wire logic       cke_i,
	input wire logic       cs_n_i,
	input wire logic [9:0] ca_rise_i,
	input wire logic       ref_tied_i,
	// Status
	input wire logic       busy_o,
	input wire logic       in_power_down_o,
	input wire logic       active_power_down_o,
	input wire logic       in_deep_sleep_o,
	input wire logic       buffers_on_o,
	input wire logic       core_power_on_o,
	input wire logic       array_valid_o,
	input wire logic       cal_ref_on_o,
	input wire logic       cal_default_o,
	input wire logic       mr_reset_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// ==========================================================
	// Low-power states
	// The reset edge is excluded because the enable history restarts low there.
	property p_pd_entry;
		!$past(sys_rst_i) && $past(cke_i) && !cke_i && cs_n_i && !busy_o
			&& !in_power_down_o && !in_deep_sleep_o |=> in_power_down_o;
	endproperty
	a_pd_entry: assert property (p_pd_entry) else $error("no power-down entry");
	property p_pd_buf;
		in_power_down_o |-> !buffers_on_o && core_power_on_o;
	endproperty
	a_pd_buf: assert property (p_pd_buf) else $error("buffers on in power-down");
	property p_pd_exit;
		in_power_down_o && cke_i |=> !in_power_down_o && buffers_on_o;
	endproperty
	a_pd_exit: assert property (p_pd_exit) else $error("no power-down exit");
	property p_act;
		active_power_down_o |-> in_power_down_o;
	endproperty
	a_act: assert property (p_act) else $error("active flag outside power-down");
	property p_dpd_entry;
		!$past(sys_rst_i) && $past(cke_i) && !cke_i && !cs_n_i && ca_rise_i[2:0] == 3'b011
			&& !busy_o && !in_power_down_o && !in_deep_sleep_o |=> in_deep_sleep_o;
	endproperty
	a_dpd_entry: assert property (p_dpd_entry) else $error("no deep sleep entry");
	property p_dpd_off;
		in_deep_sleep_o |-> !core_power_on_o && !buffers_on_o && !array_valid_o;
	endproperty
	a_dpd_off: assert property (p_dpd_off) else $error("deep sleep left power on");
	// ==========================================================
	// Calibration and reset
	property p_tied;
		ref_tied_i && $past(ref_tied_i) && !$past(sys_rst_i) && !$past(cal_ref_on_o)
			|-> cal_default_o && !cal_ref_on_o;
	endproperty
	a_tied: assert property (p_tied) else $error("tied reference calibrated");
	// The reference must already be off by the time busy drops.
	property p_ref_off;
		$fell(busy_o) |-> !cal_ref_on_o;
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("reference left on");
	property p_mr_pulse;
		mr_reset_o |-> !array_valid_o ##1 !mr_reset_o;
	endproperty
	a_mr_pulse: assert property (p_mr_pulse) else $error("bad reset pulse");
endmodule : drpc_ctrl_sva

bind drpc_ctrl drpc_ctrl_sva u_sva (.clk_i, .sys_rst_i, .cke_i, .cs_n_i, .ca_rise_i,
	.ref_tied_i, .busy_o, .in_power_down_o, .active_power_down_o, .in_deep_sleep_o,
	.buffers_on_o, .core_power_on_o, .array_valid_o, .cal_ref_on_o, .cal_default_o,
	.mr_reset_o);
`default_nettype wire

/* drpc_host.sv */
// Memory controller model that drives the command pins of the block.
`default_nettype none
module drpc_host
(
	// Clock
	input  wire logic      clk_i,
	// Command pins
	output var logic       cke_o,
	output var logic       cs_n_o,
	output var logic [9:0] ca_rise_o,
	output var logic [9:0] ca_fall_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cke_o = 1'b1;
		cs_n_o = 1'b1;
		ca_rise_o = 10'h000;
		ca_fall_o = 10'h000;
	end
	// Unselected command lines toggle so no stale value can be mistaken for a command.
	task drive(input logic k, input logic s, input logic [9:0] r, input logic [9:0] f);
		@(negedge clk_i);
		if (s)
		begin
			r = ~ca_rise_o;
			f = ~ca_fall_o;
		end
		cke_o = k;
		cs_n_o = s;
		ca_rise_o = r;
		ca_fall_o = f;
	endtask : drive
	task nop(input logic k, input int cnt);
		repeat (cnt) drive(k, 1'b1, 10'h000, 10'h000);
	endtask : nop
	task mode_reg_write_cmd(input logic [7:0] a, input logic [7:0] d);
		drive(1'b1, 1'b0, {a[5:0], 4'h0}, {d, a[7:6]});
		nop(1'b1, 1);
	endtask : mode_reg_write_cmd
endmodule : drpc_host
`default_nettype wire

/* drpc_ctrl_bench.sv */
// Self-checking bench for the reset, calibration and power-down block.
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
	$display("ERROR %0t got %0h expected %0h", $time, a, b); end end
module drpc_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_i = 1'b0;
	logic       sys_rst_i = 1'b1;
	logic       ref_tied_i = 1'b0;
	logic       cke_i, cs_n_i, busy_o, in_power_down_o, active_power_down_o;
	logic       in_deep_sleep_o, buffers_on_o, core_power_on_o, array_valid_o;
	logic       cal_ref_on_o, cal_default_o, mr_reset_o;
	logic [9:0] ca_rise_i, ca_fall_i;
	logic [7:0] cal_reg_o;
	logic [31:0] rnd;
	int         miscompares = 0;
	int         checks = 0;
	int         cyc = 0;
	int         n, i;
	int         seed = 32'h4201596c;
	logic [7:0] code_q[$] = '{8'hff, 8'hc3, 8'h56, 8'hab};
	int         dur_q[$] = '{20, 7, 12, 45};
	localparam int INIT_LEN = 20;
	drpc_host u_host (.clk_i, .cke_o(cke_i), .cs_n_o(cs_n_i), .ca_rise_o(ca_rise_i),
		.ca_fall_o(ca_fall_i));
	drpc_ctrl #(.INIT_CYC(INIT_LEN), .CAL_INIT_CYC(20)) u_dut (.clk_i, .sys_rst_i, .cke_i, .cs_n_i,
		.ca_rise_i, .ca_fall_i, .ref_tied_i, .busy_o, .in_power_down_o, .active_power_down_o,
		.in_deep_sleep_o, .buffers_on_o, .core_power_on_o, .array_valid_o, .cal_ref_on_o,
		.cal_default_o, .cal_reg_o, .mr_reset_o);
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			miscompares++;
			stop_test();
		end
	end
	task stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// ==========================================================
	// Shared sequences
	task wait_busy;
		n = 0;
		while (busy_o === 1'b1 && n < 300)
		begin
			n++;
			u_host.nop(1'b1, 1);
		end
	endtask : wait_busy
	task power_down(input logic row);
		if (row)
			u_host.drive(1'b1, 1'b0, 10'h002, rnd[9:0]);
		u_host.drive(1'b0, 1'b1, 10'h000, 10'h000);
		u_host.nop(1'b0, 3);
		`CHK(in_power_down_o, 1'b1)
		`CHK(active_power_down_o, row)
		`CHK(buffers_on_o, 1'b0)
		u_host.nop(1'b1, 3);
		`CHK(in_power_down_o, 1'b0)
		`CHK(buffers_on_o, 1'b1)
		if (row)
			u_host.drive(1'b1, 1'b0, 10'h01b, 10'h000);
		u_host.nop(1'b1, 1);
		$display("done power-down row %0d", row);
	endtask : power_down
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (16) @(negedge clk_i);
		sys_rst_i = 1'b0;
		u_host.nop(1'b1, 2);
		`CHK(busy_o, 1'b0)
		`CHK(cal_default_o, 1'b1)
		`CHK(cal_reg_o, 8'h00)
		for (i = 0; i < 4; i++)
		begin
			u_host.mode_reg_write_cmd(8'h0a, code_q[i]);
			`CHK(cal_ref_on_o, 1'b1)
			`CHK(cal_reg_o, code_q[i])
			wait_busy();
			// Busy covers the accepting cycle as well as the whole period.
			`CHK(n, dur_q[i] + 1)
			u_host.nop(1'b1, 1);
			`CHK(cal_ref_on_o, 1'b0)
			`CHK(cal_default_o, code_q[i] == 8'hc3)
		end
		$display("done calibrations");
		ref_tied_i = 1'b1;
		u_host.nop(1'b1, 2);
		u_host.mode_reg_write_cmd(8'h0a, 8'h56);
		`CHK(cal_ref_on_o, 1'b0)
		`CHK(cal_reg_o, 8'hab)
		`CHK(cal_default_o, 1'b1)
		// Only the mode write period remains when the calibration is ignored.
		wait_busy();
		`CHK(n, 5)
		ref_tied_i = 1'b0;
		u_host.nop(1'b1, 2);
		u_host.mode_reg_write_cmd(8'h0a, 8'h12);
		`CHK(cal_ref_on_o, 1'b0)
		`CHK(cal_reg_o, 8'hab)
		wait_busy();
		`CHK(n, 5)
		$display("done tied reference");
		rnd = $random(seed);
		u_host.mode_reg_write_cmd({2'b01, rnd[5:0]}, rnd[15:8]);
		`CHK(cal_reg_o, 8'hab)
		wait_busy();
		`CHK(n, 5)
		$display("done mode write");
		power_down(1'b0);
		power_down(1'b1);
		u_host.mode_reg_write_cmd(8'h3f, rnd[23:16]);
		`CHK(mr_reset_o, 1'b1)
		`CHK(array_valid_o, 1'b0)
		`CHK(cal_reg_o, 8'h00)
		`CHK(cal_default_o, 1'b1)
		wait_busy();
		`CHK(n, INIT_LEN + 1)
		`CHK(array_valid_o, 1'b1)
		$display("done mode reset");
		u_host.drive(1'b0, 1'b0, 10'h003, 10'h000);
		u_host.nop(1'b0, 3);
		`CHK(in_deep_sleep_o, 1'b1)
		`CHK(core_power_on_o, 1'b0)
		`CHK(array_valid_o, 1'b0)
		// The second cycle lets the wake edge land before busy is polled.
		u_host.nop(1'b1, 2);
		wait_busy();
		`CHK(in_deep_sleep_o, 1'b0)
		`CHK(core_power_on_o, 1'b1)
		`CHK(n, INIT_LEN + 1)
		`CHK(array_valid_o, 1'b1)
		$display("done deep sleep");
		stop_test();
	end
endmodule : drpc_ctrl_bench
`default_nettype wire
